// [core/pie_pkg.sv]
// Package: constants and types for the peripheral interrupt enable mask
package pie_pkg;

  // ****************************************
  // Register map and field positions
  // ****************************************
  localparam logic [11:0] PIE_ENABLE_OFF = 12'h000;
  localparam logic [11:0] PIE_REQ_OFF    = 12'h004;
  localparam logic [11:0] PIE_OUT_OFF    = 12'h008;
  localparam int          PIE_NSRC       = 5;
  localparam int          PIE_BIT_CWIN   = 0;
  localparam int          PIE_BIT_CDONE  = 1;
  localparam int          PIE_BIT_CARR   = 2;
  localparam int          PIE_BIT_CFALL  = 3;
  localparam int          PIE_BIT_CRISE  = 4;
  localparam logic [4:0]  PIE_ENABLE_RST = 5'h00;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic cmp_rise;
    logic cmp_fall;
    logic counter_array;
    logic conv_done;
    logic conv_window;
  } pie_src_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pie_apb_req_s;

endpackage

// [core/pie_gate.sv]
// Per-source registered gate of requests by enable bits
`timescale 1ns/1ps
module pie_gate
  import pie_pkg::*;
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Requests and enables
  input  wire pie_src_s         req,
  input  wire logic [4:0]       enable,
  // Gated requests
  output      pie_src_s         gated
);

  logic [4:0] next_gated;
  logic [4:0] gated_q;

  // ****************************************
  // Gating
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < PIE_NSRC; i++) begin : g_src
      always_comb begin
        next_gated[i] = req[i] & enable[i];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gated_q <= 5'h00;
    end else begin
      gated_q <= next_gated;
    end
  end

  assign gated = gated_q;

endmodule

// [core/pie_mask.sv]
// Top: APB-reached enable mask gating five peripheral interrupt requests
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module pie_mask
  import pie_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // Peripheral request levels
  input  wire logic        cmp_rise_req,
  input  wire logic        cmp_fall_req,
  input  wire logic        counter_array_req,
  input  wire logic        conv_done_flag,
  input  wire logic        conv_window_req,
  // Masked requests to core
  output      logic        cmp_rise_irq,
  output      logic        cmp_fall_irq,
  output      logic        counter_array_irq,
  output      logic        conv_done_irq,
  output      logic        conv_window_irq
);

  pie_apb_req_s bus;
  pie_src_s     src;
  pie_src_s     gated;
  logic [4:0]   enable;
  logic [4:0]   next_enable;
  logic [31:0]  next_prdata;
  logic         next_pready;
  logic         next_pslverr;
  logic         setup;
  logic         hit;

  assign bus = '{psel: psel, penable: penable, pwrite: pwrite,
                 paddr: paddr, pwdata: pwdata};
  assign src = '{cmp_rise: cmp_rise_req, cmp_fall: cmp_fall_req,
                 counter_array: counter_array_req,
                 conv_done: conv_done_flag, conv_window: conv_window_req};

  // ****************************************
  // APB access, no wait states
  // ****************************************
  assign setup = bus.psel & ~bus.penable;
  assign hit   = (bus.paddr == PIE_ENABLE_OFF) |
                 (bus.paddr == PIE_REQ_OFF) |
                 (bus.paddr == PIE_OUT_OFF);

  always_comb begin
    next_enable  = enable;
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    if (bus.psel & bus.penable & pready) begin
      next_prdata = 32'h0000_0000;
    end
    if (setup) begin
      next_pready  = 1'b1;
      next_pslverr = ~hit;
      next_prdata  = 32'h0000_0000;
      if (!bus.pwrite) begin
        unique case (bus.paddr)
          PIE_ENABLE_OFF: next_prdata = {27'h0, enable};
          PIE_REQ_OFF:    next_prdata = {27'h0, src};
          PIE_OUT_OFF:    next_prdata = {27'h0, gated};
          default:        next_prdata = 32'h0000_0000;
        endcase
      end
    end
    if (bus.psel & bus.penable & pready & bus.pwrite & pstrb[0] &
        (bus.paddr == PIE_ENABLE_OFF)) begin
      next_enable = bus.pwdata[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable  <= PIE_ENABLE_RST;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      enable  <= next_enable;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************
  // Request gating
  // ****************************************
  // sources untouched, gate only
  pie_gate u_gate (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (src),
    .enable  (enable),
    .gated   (gated)
  );

  assign cmp_rise_irq      = gated.cmp_rise;
  assign cmp_fall_irq      = gated.cmp_fall;
  assign counter_array_irq = gated.counter_array;
  assign conv_done_irq     = gated.conv_done;
  assign conv_window_irq   = gated.conv_window;

  // ****************************************
  // Assertions
  // ****************************************
  property p_rise;
    @(posedge pclk) disable iff (!presetn)
      ##1 cmp_rise_irq == $past(cmp_rise_req & enable[PIE_BIT_CRISE]);
  endproperty
  a_rise: assert property (p_rise) else $error("rise gate wrong");

  property p_fall;
    @(posedge pclk) disable iff (!presetn)
      !enable[PIE_BIT_CFALL] |=> !cmp_fall_irq;
  endproperty
  a_fall: assert property (p_fall) else $error("fall leaked");

  property p_carr;
    @(posedge pclk) disable iff (!presetn)
      (counter_array_req & enable[PIE_BIT_CARR]) |=> counter_array_irq;
  endproperty
  a_carr: assert property (p_carr) else $error("array blocked");

  property p_done;
    @(posedge pclk) disable iff (!presetn)
      ##1 conv_done_irq == $past(conv_done_flag & enable[PIE_BIT_CDONE]);
  endproperty
  a_done: assert property (p_done) else $error("done gate wrong");

  property p_win;
    @(posedge pclk) disable iff (!presetn)
      !enable[PIE_BIT_CWIN] |=> !conv_window_irq;
  endproperty
  a_win: assert property (p_win) else $error("window leaked");

  property p_reapply;
    @(posedge pclk) disable iff (!presetn)
      (conv_window_req & !enable[PIE_BIT_CWIN]
       ##1 conv_window_req & enable[PIE_BIT_CWIN]) |=> conv_window_irq;
  endproperty
  a_reapply: assert property (p_reapply)
    else $error("not re-presented");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
      (psel & !penable) |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready late"); // bus timing

  property p_write;
    @(posedge pclk) disable iff (!presetn)
      (psel & penable & pready & pwrite & pstrb[0] &
       paddr == PIE_ENABLE_OFF) |=> enable == $past(pwdata[4:0]);
  endproperty
  a_write: assert property (p_write) else $error("enable not written"); // bus

  // ****************************************
  // Per-source and bus checks
  // ****************************************
  property p_rise_block;
    @(posedge pclk) disable iff (!presetn)
      !enable[PIE_BIT_CRISE] |=> !cmp_rise_irq;
  endproperty
  a_rise_block: assert property (p_rise_block)
    else $error("rise leaked");

  property p_rise_pass;
    @(posedge pclk) disable iff (!presetn)
      (cmp_rise_req & enable[PIE_BIT_CRISE]) |=> cmp_rise_irq;
  endproperty
  a_rise_pass: assert property (p_rise_pass)
    else $error("rise blocked");

  property p_fall_pass;
    @(posedge pclk) disable iff (!presetn)
      (cmp_fall_req & enable[PIE_BIT_CFALL]) |=> cmp_fall_irq;
  endproperty
  a_fall_pass: assert property (p_fall_pass)
    else $error("fall blocked");

  property p_fall_exact;
    @(posedge pclk) disable iff (!presetn)
      ##1 cmp_fall_irq == $past(cmp_fall_req & enable[PIE_BIT_CFALL]);
  endproperty
  a_fall_exact: assert property (p_fall_exact)
    else $error("fall gate wrong");

  property p_carr_block;
    @(posedge pclk) disable iff (!presetn)
      !enable[PIE_BIT_CARR] |=> !counter_array_irq;
  endproperty
  a_carr_block: assert property (p_carr_block)
    else $error("array leaked");

  property p_carr_exact;
    @(posedge pclk) disable iff (!presetn)
      ##1 counter_array_irq ==
          $past(counter_array_req & enable[PIE_BIT_CARR]);
  endproperty
  a_carr_exact: assert property (p_carr_exact)
    else $error("array gate wrong");

  property p_done_block;
    @(posedge pclk) disable iff (!presetn)
      !enable[PIE_BIT_CDONE] |=> !conv_done_irq;
  endproperty
  a_done_block: assert property (p_done_block)
    else $error("done leaked");

  property p_done_pass;
    @(posedge pclk) disable iff (!presetn)
      (conv_done_flag & enable[PIE_BIT_CDONE]) |=> conv_done_irq;
  endproperty
  a_done_pass: assert property (p_done_pass)
    else $error("done blocked");

  property p_win_pass;
    @(posedge pclk) disable iff (!presetn)
      (conv_window_req & enable[PIE_BIT_CWIN]) |=> conv_window_irq;
  endproperty
  a_win_pass: assert property (p_win_pass)
    else $error("window blocked");

  property p_win_exact;
    @(posedge pclk) disable iff (!presetn)
      ##1 conv_window_irq == $past(conv_window_req & enable[PIE_BIT_CWIN]);
  endproperty
  a_win_exact: assert property (p_win_exact)
    else $error("window gate wrong");

  property p_rise_again;
    @(posedge pclk) disable iff (!presetn)
      (cmp_rise_req & !enable[PIE_BIT_CRISE]
       ##1 cmp_rise_req & enable[PIE_BIT_CRISE]) |=> cmp_rise_irq;
  endproperty
  a_rise_again: assert property (p_rise_again)
    else $error("rise not re-presented");

  property p_fall_again;
    @(posedge pclk) disable iff (!presetn)
      (cmp_fall_req & !enable[PIE_BIT_CFALL]
       ##1 cmp_fall_req & enable[PIE_BIT_CFALL]) |=> cmp_fall_irq;
  endproperty
  a_fall_again: assert property (p_fall_again)
    else $error("fall not re-presented");

  property p_carr_again;
    @(posedge pclk) disable iff (!presetn)
      (counter_array_req & !enable[PIE_BIT_CARR]
       ##1 counter_array_req & enable[PIE_BIT_CARR]) |=> counter_array_irq;
  endproperty
  a_carr_again: assert property (p_carr_again)
    else $error("array not re-presented");

  property p_done_again;
    @(posedge pclk) disable iff (!presetn)
      (conv_done_flag & !enable[PIE_BIT_CDONE]
       ##1 conv_done_flag & enable[PIE_BIT_CDONE]) |=> conv_done_irq;
  endproperty
  a_done_again: assert property (p_done_again)
    else $error("done not re-presented");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) // bus timing
    else $error("pready held");

  property p_err_ready;
    @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) // bus timing
    else $error("pslverr alone");

  property p_rd_enable;
    @(posedge pclk) disable iff (!presetn)
      (setup & !pwrite & paddr == PIE_ENABLE_OFF) |=>
        prdata == {27'h0, $past(enable)};
  endproperty
  a_rd_enable: assert property (p_rd_enable) // bus read
    else $error("enable read wrong");

  property p_rd_req;
    @(posedge pclk) disable iff (!presetn)
      (setup & !pwrite & paddr == PIE_REQ_OFF) |=>
        prdata == {27'h0, $past(src)};
  endproperty
  a_rd_req: assert property (p_rd_req) // bus read
    else $error("request read wrong");

  property p_rd_out;
    @(posedge pclk) disable iff (!presetn)
      (setup & !pwrite & paddr == PIE_OUT_OFF) |=>
        prdata == {27'h0, $past(gated)};
  endproperty
  a_rd_out: assert property (p_rd_out) // bus read
    else $error("gated read wrong");

  property p_wr_hold;
    @(posedge pclk) disable iff (!presetn)
      !(psel & penable & pready & pwrite & pstrb[0] &
        paddr == PIE_ENABLE_OFF) |=> $stable(enable);
  endproperty
  a_wr_hold: assert property (p_wr_hold) // bus write
    else $error("enable changed unasked");

endmodule

// [tb/pie_src_model.sv]
// Peripheral sources holding pending request flags
`timescale 1ns/1ps
module pie_src_model
  import pie_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Raise and acknowledge
  input  wire logic [4:0] set,
  input  wire logic [4:0] ack,
  // Pending flags
  output      pie_src_s   req
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= '0;
    end else begin
      req <= (req | set) & ~ack;
    end
  end
endmodule

// [tb/tb.sv]
// Self-checking bench for the interrupt enable mask
`timescale 1ns/1ps
module tb
  import pie_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [4:0]  set, ack;
  wire  [4:0]  irq;
  pie_src_s    req;
  int          n_errors, n_checks;

  pie_src_model src (.pclk(pclk), .presetn(presetn), .set(set), .ack(ack),
                     .req(req));
  pie_mask uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_rise_req(req.cmp_rise), .cmp_fall_req(req.cmp_fall),
    .counter_array_req(req.counter_array), .conv_done_flag(req.conv_done),
    .conv_window_req(req.conv_window), .cmp_rise_irq(irq[4]),
    .cmp_fall_irq(irq[3]), .counter_array_irq(irq[2]),
    .conv_done_irq(irq[1]), .conv_window_irq(irq[0]));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    set = 5'h00;
    ack = 5'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, PIE_ENABLE_OFF, 32'h0, 4'hF);
    check(rd, 32'(PIE_ENABLE_RST));
    set <= 5'h1F;
    @(posedge pclk);
    set <= 5'h00;
    settle();
    check(32'(irq), 32'h0); // all masked
    for (int i = 0; i < PIE_NSRC; i++) begin
      apb(1'b1, PIE_ENABLE_OFF, 32'h1 << i, 4'hF);
      settle();
      check(32'(irq), 32'h1 << i); // one bit
      apb(1'b0, PIE_OUT_OFF, 32'h0, 4'hF);
      check(rd, 32'h1 << i); // gated view
    end
    apb(1'b1, PIE_ENABLE_OFF, 32'h0, 4'hF);
    apb(1'b0, PIE_REQ_OFF, 32'h0, 4'hF);
    check(rd, 32'h1F); // flags kept
    apb(1'b1, PIE_ENABLE_OFF, 32'hFFFF_FFFF, 4'hF);
    settle();
    check(32'(irq), 32'h1F); // presented again
    apb(1'b1, PIE_ENABLE_OFF, 32'h0, 4'h0);
    apb(1'b1, 12'h00C, 32'h0, 4'hF);
    check(32'(err), 32'h1);
    settle();
    check(32'(irq), 32'h1F);
    apb(1'b0, 12'h00C, 32'h0, 4'hF);
    check(rd, 32'h0);
    ack <= 5'h10;
    @(posedge pclk);
    ack <= 5'h00;
    settle();
    check(32'(irq), 32'h0F); // follows source
    report_and_stop();
  end
endmodule
